// File: design/status_led_blink_controller.v
// Functional notes
// - 57h then 46h relocks configuration mode
// - index at 302h, data at 303h
// - unit registers 30h, 60h, 61h answer only when device is 5
// - activation register 30h, bit0 activates
// - index 60h holds base high byte
// - index 61h holds base low byte
// - lamp register at base, reset 01h
// - upper four bits ignored, read zero
// - red bits 3:2, green bits 1:0
// - modes off, 8 Hz, 1 Hz, on
// - red and green are separate outputs
`timescale 1ns/100ps
`default_nettype none
`include "lamp_defs.vh"

module status_led_blink_controller #(
  parameter FAST_HALF = `FAST_HALF,
  parameter SLOW_HALF = `SLOW_HALF
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // i/o bus request, one-cycle strobes on the same clock
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_wr,
  input wire io_rd,
  // i/o bus answer, one cycle after each read strobe
  output reg [7:0] io_rdata,
  output reg io_rdata_valid,
  // bicolour status lamp drive
  output reg lamp_red,
  output reg lamp_green
);

  // key sequence states; two-step keys so that a stray 46h or 57h
  // on its own never opens or closes configuration mode
  localparam [1:0] ST_LOCKED = 2'b00;
  localparam [1:0] ST_HALF_KEY = 2'b01;
  localparam [1:0] ST_OPEN = 2'b10;
  localparam [1:0] ST_HALF_EXIT = 2'b11;

  // configuration side state
  reg [1:0] cfg_state_q; // configuration key state
  reg [7:0] cfg_index_q; // selected configuration index
  reg [7:0] dev_select_q; // logical_device_select register
  reg [7:0] unit_activate_q; // activation register
  reg [15:0] io_base_q; // programmed base address
  // lamp side state; only four mode bits are kept, the rest never
  reg [3:0] lamp_mode_q; // lamp_mode_control significant bits
  reg [31:0] fast_cnt_q; // fast divider counter
  reg [31:0] slow_cnt_q; // slow divider counter
  reg fast_phase_q; // 8 Hz square wave
  reg slow_phase_q; // 1 Hz square wave

  // access qualifiers, decoded from the held configuration state and this cycle's address and strobes
  wire cfg_open; // index and data ports usable
  wire dev_hit; // lamp unit selected
  wire unit_on; // lamp unit activated
  wire idx_wr; // any write to the index port
  wire dat_wr; // accepted write to the data port
  wire dat_rd; // accepted read of the data port
  wire idx_rd; // accepted read of the index port
  wire lamp_hit; // address matches the lamp register
  wire lamp_wr; // write to the lamp register
  wire lamp_rd; // read of the lamp register
  // next lamp levels, bit 1 red and bit 0 green
  wire [1:0] lamp_d;

  // open covers the half-exit step too: a bare 57h is still an index
  assign cfg_open = (cfg_state_q == ST_OPEN) ||
                    (cfg_state_q == ST_HALF_EXIT);
  assign dev_hit = (dev_select_q == `LAMP_DEV_NUM);
  assign unit_on = unit_activate_q[`ACT_BIT];
  // index writes reach the key tracker whether open or not
  assign idx_wr = io_wr && (io_addr == `CFG_INDEX_PORT);
  assign dat_wr = io_wr && (io_addr == `CFG_DATA_PORT) && cfg_open;
  // reads of the data port pass the same gate as writes
  assign dat_rd = io_rd && (io_addr == `CFG_DATA_PORT) && cfg_open;
  // the index echo stays hidden while locked, like the data port
  assign idx_rd = io_rd && (io_addr == `CFG_INDEX_PORT) && cfg_open;
  // lamp register at base plus offset; the sum wraps at 16 bits
  assign lamp_hit = (io_addr == io_base_q + `LAMP_OFFSET);
  assign lamp_wr = io_wr && unit_on && lamp_hit;
  assign lamp_rd = io_rd && unit_on && lamp_hit;

  // key sequence tracker on writes to the index port
  // reads never move the key, so probing the ports is harmless
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_state_q <= ST_LOCKED;
    end else if (idx_wr) begin
      case (cfg_state_q)
        ST_LOCKED: begin
          if (io_wdata == `KEY_FIRST) begin
            cfg_state_q <= ST_HALF_KEY;
          end
        end
        ST_HALF_KEY: begin
          if (io_wdata == `KEY_SECOND) begin
            cfg_state_q <= ST_OPEN;
          end else if (io_wdata != `KEY_FIRST) begin
            // a wrong byte starts over; a repeated 46h keeps waiting
            cfg_state_q <= ST_LOCKED;
          end
        end
        ST_OPEN: begin
          if (io_wdata == `KEY_SECOND) begin
            cfg_state_q <= ST_HALF_EXIT;
          end
        end
        ST_HALF_EXIT: begin
          if (io_wdata == `KEY_FIRST) begin
            cfg_state_q <= ST_LOCKED;
          end else if (io_wdata != `KEY_SECOND) begin
            // any other byte was a plain index, so stay open
            cfg_state_q <= ST_OPEN;
          end
        end
        default: begin
          // unreachable codes fall back to the safe locked state
          cfg_state_q <= ST_LOCKED;
        end
      endcase
    end
  end

  // index latch; lock key bytes also land here, which is harmless
  // bytes written while locked never become an index
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_index_q <= 8'h00;
    end else if (idx_wr && cfg_open) begin
      cfg_index_q <= io_wdata;
    end
  end

  // configuration register writes through the data port
  always @(posedge clk) begin
    if (!rst_n) begin
      dev_select_q <= `DEV_SELECT_RST;
      unit_activate_q <= `ACTIVATE_RST;
      io_base_q <= `BASE_RST;
    end else if (dat_wr) begin
      // the select register serves every unit, so it is not gated
      // device number register
      if (cfg_index_q == `IDX_DEV_SELECT) begin
        dev_select_q <= io_wdata;
      end
      // registers of other units are absent here; their writes drop
      // base bytes land one at a time, so the lamp decode follows each
      if (dev_hit) begin
        if (cfg_index_q == `IDX_ACTIVATE) begin
          unit_activate_q <= io_wdata;
        end
        if (cfg_index_q == `IDX_BASE_HIGH) begin
          io_base_q[15:8] <= io_wdata;
        end
        if (cfg_index_q == `IDX_BASE_LOW) begin
          io_base_q[7:0] <= io_wdata;
        end
      end
    end
  end

  // lamp control register
  always @(posedge clk) begin
    if (!rst_n) begin
      lamp_mode_q <= `LAMP_RST;
    end else if (lamp_wr) begin
      // writes while inactive never get here and the mode holds
      // upper bits dropped
      lamp_mode_q <= io_wdata[3:0];
    end
  end

  // read mux; one cycle after the strobe, zero for anything unmapped
  always @(posedge clk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      // every read strobe is answered, mapped or not
      io_rdata_valid <= io_rd;
      // zero between answers keeps the bus quiet
      io_rdata <= 8'h00;
      // lamp first: a base that overlaps the pair still reaches it
      if (lamp_rd) begin
        io_rdata <= {4'h0, lamp_mode_q};
      end else if (dat_rd) begin
        // data port shows the indexed register
        if (cfg_index_q == `IDX_DEV_SELECT) begin
          io_rdata <= dev_select_q;
        end else if (dev_hit && cfg_index_q == `IDX_ACTIVATE) begin
          io_rdata <= unit_activate_q;
        end else if (dev_hit && cfg_index_q == `IDX_BASE_HIGH) begin
          io_rdata <= io_base_q[15:8];
        end else if (dev_hit && cfg_index_q == `IDX_BASE_LOW) begin
          io_rdata <= io_base_q[7:0];
        end
      end else if (idx_rd) begin
        // index port echoes the current index
        io_rdata <= cfg_index_q;
      end
    end
  end

  // free-running dividers; phases are shared so both lamps blink in step
  // limitation: the phase runs free, so a newly chosen blink mode may
  // show a first half period shorter than the ones that follow
  // 32-bit counters hold the slow half period at the full clock rate
  always @(posedge clk) begin
    if (!rst_n) begin
      fast_cnt_q <= 32'h00000000;
      slow_cnt_q <= 32'h00000000;
      fast_phase_q <= 1'b0;
      slow_phase_q <= 1'b0;
    end else begin
      // fast divider
      // wrap one short so each phase lasts exactly FAST_HALF cycles
      if (fast_cnt_q == FAST_HALF - 1) begin
        fast_cnt_q <= 32'h00000000;
        fast_phase_q <= ~fast_phase_q;
      end else begin
        // count toward the wrap
        fast_cnt_q <= fast_cnt_q + 32'h00000001;
      end
      // slow divider
      // same wrap rule, so the slow phase is an exact square wave
      if (slow_cnt_q == SLOW_HALF - 1) begin
        slow_cnt_q <= 32'h00000000;
        slow_phase_q <= ~slow_phase_q;
      end else begin
        // count toward the wrap
        slow_cnt_q <= slow_cnt_q + 32'h00000001;
      end
    end
  end

  // mode decode for one lamp field
  function lamp_level;
    input [1:0] mode;
    input fast;
    input slow;
    begin
      // mode encoding
      // off and steady ignore the dividers, so they settle at once
      case (mode)
        `MODE_OFF: lamp_level = 1'b0;
        `MODE_FAST: lamp_level = fast;
        `MODE_SLOW: lamp_level = slow;
        default: lamp_level = 1'b1;
      endcase
    end
  endfunction

  // one decoder per lamp field; index 1 is red, index 0 is green
  genvar lamp_i;
  generate
    for (lamp_i = 0; lamp_i < 2; lamp_i = lamp_i + 1) begin : g_lamp
      assign lamp_d[lamp_i] = lamp_level(
        lamp_mode_q[`GREEN_LO + 2 * lamp_i +: 2],
        fast_phase_q, slow_phase_q);
    end
  endgenerate

  // registered lamp outputs; the register keeps the pins glitch free
  always @(posedge clk) begin
    if (!rst_n) begin
      lamp_red <= 1'b0;
      lamp_green <= 1'b0;
    end else begin
      lamp_red <= lamp_d[1];
      lamp_green <= lamp_d[0];
    end
  end

endmodule // status_led_blink_controller
`default_nettype wire

// File: design/lamp_defs.vh
`ifndef LAMP_DEFS_VH
`define LAMP_DEFS_VH
// i/o port addresses of the configuration pair
`define CFG_INDEX_PORT 16'h0302
`define CFG_DATA_PORT 16'h0303
// unlock and lock key bytes
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'h57
// configuration register indices
`define IDX_DEV_SELECT 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
// logical device number of the lamp unit
`define LAMP_DEV_NUM 8'h05
// lamp register offset from base
`define LAMP_OFFSET 16'h0000
// reset values
`define ACTIVATE_RST 8'h00
`define LAMP_RST 4'h1
`define BASE_RST 16'h0000
`define DEV_SELECT_RST 8'h00
// field positions
`define RED_HI 3
`define RED_LO 2
`define GREEN_HI 1
`define GREEN_LO 0
`define ACT_BIT 0
// lamp modes
`define MODE_OFF 2'b00
`define MODE_FAST 2'b01
`define MODE_SLOW 2'b10
`define MODE_ON 2'b11
// timing: clock rate and blink rates
`define CLK_HZ 125000000
`define FAST_HZ 8
`define SLOW_HZ 1
// half-period cycle counts (50 percent duty)
`define FAST_HALF (`CLK_HZ / (2 * `FAST_HZ))
`define SLOW_HALF (`CLK_HZ / (2 * `SLOW_HZ))
`endif

// File: sim/lamp_props.sv
`timescale 1ns/100ps
`default_nettype none
module lamp_props #(
  parameter FAST_HALF = 4,
  parameter SLOW_HALF = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus strobes and answer
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  // lamp drive
  input wire logic lamp_red,
  input wire logic lamp_green
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the run counters saturate, so long half periods compare at the cap
  localparam int RUN_MIN = (FAST_HALF - 1 > 255) ? 255 : FAST_HALF - 1;
  // ages saturate so that long steady modes never wrap round
  logic [7:0] wr_age_q;
  logic [7:0] red_run_q;
  logic [7:0] grn_run_q;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  // cycles since the last write and since each lamp edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_age_q <= 8'h00;
      red_run_q <= 8'h00;
      grn_run_q <= 8'h00;
    end else begin
      wr_age_q <= io_wr ? 8'h00 : inc(wr_age_q);
      red_run_q <= $changed(lamp_red) ? 8'h00 : inc(red_run_q);
      grn_run_q <= $changed(lamp_green) ? 8'h00 : inc(grn_run_q);
    end
  end
  sequence rd_lone;
    io_rd ##1 !io_rd;
  endsequence
  sequence red_dark;
    !lamp_red [*2];
  endsequence
  a_rd_answer: assert property (io_rd |=> io_rdata_valid)
    else $error("read got no answer");
  a_valid_cause: assert property (io_rdata_valid |-> $past(io_rd))
    else $error("answer without a read");
  a_valid_single: assert property (rd_lone |=> !io_rdata_valid)
    else $error("answer stood too long");
  a_idle_zero: assert property (
    !io_rdata_valid |-> io_rdata == 8'h00) else $error("idle data not zero");
  a_write_quiet: assert property (io_wr |=> !io_rdata_valid)
    else $error("write produced an answer");
  a_reset_dark: assert property ($rose(rst_n) |-> red_dark)
    else $error("red lit after reset");
  // edges soon after a write are exempt, the mode may have just changed
  a_red_half: assert property (
    $changed(lamp_red) && wr_age_q > FAST_HALF + 2 |->
    red_run_q >= RUN_MIN) else $error("red half period short");
  a_green_half: assert property (
    $changed(lamp_green) && wr_age_q > FAST_HALF + 2 |->
    grn_run_q >= RUN_MIN) else $error("green half period short");
endmodule // lamp_props
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int FH = 4;
  localparam int SH = 32;
  logic clk, rst_n, io_wr, io_rd;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  wire [7:0] io_rdata;
  wire io_rdata_valid, lamp_red, lamp_green;
  int num_errors = 0;
  int checks_done = 0;
  // model: key state 0 locked, 1 half open, 2 open, 3 half closed
  int lk = 0;
  logic [7:0] idx = 8'h00, dev = 8'h00, act = 8'h00;
  logic [15:0] base = 16'h0000;
  logic [3:0] lamp = 4'h1;
  logic [31:0] seed = 32'hC00F;
  int tr, tg;
  status_led_blink_controller #(.FAST_HALF(FH), .SLOW_HALF(SH)) dut (
    .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .lamp_red(lamp_red),
    .lamp_green(lamp_green));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected read data from the model state
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    if (a == base && act[0]) return {4'h0, lamp};
    if (a == 16'h0302 && lk >= 2) return idx;
    if (a != 16'h0303 || lk < 2) return 8'h00;
    if (idx == 8'h07) return dev;
    if (dev != 8'h05) return 8'h00;
    if (idx == 8'h30) return act;
    if (idx == 8'h60) return base[15:8];
    if (idx == 8'h61) return base[7:0];
    return 8'h00;
  endfunction
  // one write strobe, then the model follows it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    if (a == base && act[0]) lamp = d[3:0];
    else if (a == 16'h0302) begin
      if (lk >= 2) idx = d;
      case (lk)
        0: lk = (d == 8'h46) ? 1 : 0;
        1: lk = (d == 8'h57) ? 2 : (d == 8'h46) ? 1 : 0;
        2: lk = (d == 8'h57) ? 3 : 2;
        default: lk = (d == 8'h46) ? 0 : (d == 8'h57) ? 3 : 2;
      endcase
    end else if (a == 16'h0303 && lk >= 2) begin
      if (idx == 8'h07) dev = d;
      else if (dev == 8'h05 && idx == 8'h30) act = d;
      else if (dev == 8'h05 && idx == 8'h60) base[15:8] = d;
      else if (dev == 8'h05 && idx == 8'h61) base[7:0] = d;
    end
  endtask
  task automatic rd(input logic [15:0] a);
    logic [7:0] e;
    e = exp_rd(a);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    chk("read valid", {7'h00, io_rdata_valid}, 8'h01);
    chk("read data", io_rdata, e);
  endtask
  task automatic sel(input logic [7:0] i, input logic [7:0] d);
    wr(16'h0302, i);
    wr(16'h0303, d);
  endtask
  // count lamp edges over 64 cycles
  task automatic count_tog(output int r, output int g);
    logic pr, pg;
    r = 0;
    g = 0;
    pr = lamp_red;
    pg = lamp_green;
    repeat (64) begin
      @(negedge clk);
      r += int'(lamp_red !== pr);
      g += int'(lamp_green !== pg);
      pr = lamp_red;
      pg = lamp_green;
    end
  endtask
  function automatic logic [7:0] tog_exp(input int m);
    return (m == 1) ? 8'(64 / FH) : (m == 2) ? 8'(64 / SH) : 8'h00;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    {io_addr, io_wdata, io_wr, io_rd, rst_n} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    sel(8'h07, 8'h05);
    rd(16'h0303);
    rd(16'h0400);
    wr(16'h0302, 8'h46);
    wr(16'h0302, 8'h46);
    wr(16'h0302, 8'h57);
    sel(8'h07, 8'h03);
    sel(8'h60, 8'hAA);
    rd(16'h0303);
    sel(8'h07, 8'h05);
    rd(16'h0303);
    wr(16'h0302, 8'h30);
    rd(16'h0303);
    seed = lfsr(seed);
    sel(8'h60, seed[15:8] | 8'h10);
    rd(16'h0303);
    sel(8'h61, seed[7:0]);
    rd(16'h0303);
    sel(8'h30, 8'h01);
    rd(16'h0303);
    // a lone 57h followed by another byte must leave the mode open
    wr(16'h0302, 8'h57);
    wr(16'h0302, 8'h30);
    rd(16'h0303);
    wr(16'h0302, 8'h57);
    wr(16'h0302, 8'h46);
    rd(16'h0303);
    rd(base);
    repeat (4) begin
      seed = lfsr(seed);
      wr(base, seed[7:0]);
      rd(base);
    end
    for (int m = 0; m < 4; m++) begin
      wr(base, 8'(m * 4 + 3 - m));
      repeat (4) @(negedge clk);
      count_tog(tr, tg);
      chk("red toggles", 8'(tr), tog_exp(m));
      chk("green toggles", 8'(tg), tog_exp(3 - m));
      // blinking levels hang on the free phase, so only steady ones count
      tg = (m % 3 == 0) ? 3 : 0;
      tr = (m == 0) ? 1 : (m == 3) ? 2 : 0;
      chk("levels", {6'h00, lamp_red, lamp_green} & 8'(tg), 8'(tr));
    end
    wr(base, 8'h0F);
    repeat (3) @(negedge clk);
    chk("orange", {6'h00, lamp_red, lamp_green}, 8'h03);
    give_verdict();
  end
endmodule // testbench
bind status_led_blink_controller lamp_props #(
  .FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) props_i (
  .clk(clk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd),
  .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
  .lamp_red(lamp_red), .lamp_green(lamp_green));
`default_nettype wire
